// >>> isr_pkg.sv
package isr_pkg;
  localparam int unsigned ISR_CLK_HZ = 100_000_000;
  // sample rate in millihertz, as printed: 819.2 samples per second
  localparam longint unsigned ISR_SAMPLE_MHZ = 819_200;
  localparam int unsigned ISR_SAMPLE_CYC =
    int'((longint'(ISR_CLK_HZ) * 1000) / ISR_SAMPLE_MHZ);
  // power-up self initialisation time, microseconds
  localparam int unsigned ISR_INIT_US = 220_000;
  localparam int unsigned ISR_INIT_CYC = ISR_INIT_US * (ISR_CLK_HZ / 1_000_000);
  localparam int unsigned ISR_WORD_BITS = 16;
  localparam int unsigned ISR_NREG = 14;
  localparam logic [6:0] ISR_FIRST_ADDR = 7'h02;
  localparam logic [6:0] ISR_LAST_ADDR = 7'h1C;
  localparam logic [15:0] ISR_BURST_CMD = 16'h4200;
  localparam int unsigned ISR_FRESH_BIT = 15;
  localparam int unsigned ISR_ALARM_BIT = 14;
  localparam logic [15:0] ISR_IDLE_WORD = 16'h0000;
endpackage : isr_pkg

// >>> isr_out_mem.sv
`timescale 1ns/1ns
`default_nettype none
// output register file: one word per output register, registered read port
module isr_out_mem
  import isr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic wr_en,
  input wire logic [3:0] wr_idx,
  input wire logic [15:0] wr_data,
  input wire logic [3:0] rd_idx,
  output logic [15:0] rd_data
);
  logic [15:0] mem_reg [ISR_NREG];

  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem_reg[wr_idx] <= wr_data;
    end
    rd_data <= mem_reg[rd_idx];
  end
endmodule : isr_out_mem
`default_nettype wire

// >>> isr_spi_readout.sv
// Notes on behaviour
// - self-start after reset, refresh output words at 819.2 samples per second.
// - pulse sample_done_pin high at the end of each sample cycle.
// - slave in mode 3, 16-bit words, most significant bit first.
// - output line changes on each falling serial clock edge.
// - input line captured on each rising serial clock edge.
// - single read: request word, then the register comes back next word.
// - low byte of a read request is ignored.
// - register byte address sits in the upper request byte.
// - full duplex; reads chain back to back.
// - command 0x4200 starts a burst of all output words.
// - burst words go out in ascending address order.
// - burst words follow back to back, with no gap clock between them.
// - fourth digital pin is general I/O or external sync clock.
// - burst covers addresses 0x02 to 0x1C in steps of two.
// - bit 15 fresh flag, bit 14 alarm, measurement in 13..0.
`timescale 1ns/1ns
`default_nettype none
module isr_spi_readout
  import isr_pkg::*;
#(
  parameter int unsigned INIT_CYC = ISR_INIT_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  // measurement feed from the sensor front end
  input wire logic [13:0] meas_data,
  input wire logic meas_alarm,
  input wire logic sync_mode_en,
  output logic sample_done_pin,
  input wire logic sync_clock_input_pin_in,
  output logic sync_clock_input_pin_out,
  output logic sync_clock_input_pin_oe_n,
  input wire logic general_io_b_out,
  input wire logic general_io_b_oe_n
);
  logic rst_s1_reg, rst_s2_reg;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end
  wire logic rstn = rst_s2_reg;

  // two-flop synchronisers for the pins; stage two is the pin value, stage three is read only for edge detection
  logic [3:0] pin_s1_reg, pin_s2_reg, pin_s3_reg;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pin_s1_reg <= 4'hf;
      pin_s2_reg <= 4'hf;
      pin_s3_reg <= 4'hf;
    end else begin
      pin_s1_reg <= {sync_clock_input_pin_in, spi_mosi, spi_cs_n, spi_sclk};
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
    end
  end
  wire logic sclk_s = pin_s2_reg[0];
  wire logic cs_n_s = pin_s2_reg[1];
  wire logic mosi_s = pin_s2_reg[2];
  wire logic sync_s = pin_s2_reg[3];
  wire logic sclk_rise = sclk_s & ~pin_s3_reg[0];
  wire logic sclk_fall = ~sclk_s & pin_s3_reg[0];
  wire logic cs_rise = cs_n_s & ~pin_s3_reg[1];
  wire logic sync_rise = sync_s & ~pin_s3_reg[3];

  // sample timing: internal divider or the external sync clock
  typedef enum logic [1:0] {ISR_INIT, ISR_RUN} isr_phase_t;
  isr_phase_t phase_reg, phase_next;
  logic [31:0] tmr_reg, tmr_next;
  logic [3:0] fill_reg, fill_next;
  logic filling_reg, filling_next;
  logic done_reg, done_next;
  logic [13:0] fresh_reg, fresh_next;
  logic tick;

  always_comb begin
    phase_next = phase_reg;
    tmr_next = tmr_reg;
    fill_next = fill_reg;
    filling_next = filling_reg;
    done_next = 1'b0;
    tick = 1'b0;
    unique case (phase_reg)
      ISR_INIT: begin
        tmr_next = tmr_reg + 32'h0000_0001;
        if (tmr_reg >= INIT_CYC - 1) begin
          phase_next = ISR_RUN;
          // first sample follows init at once, not a full period later
          tmr_next = 32'(ISR_SAMPLE_CYC - 1);
        end
      end
      ISR_RUN: begin
        if (sync_mode_en) begin
          tick = sync_rise;
          tmr_next = 32'h0000_0000;
        end else if (tmr_reg >= ISR_SAMPLE_CYC - 1) begin
          tick = 1'b1;
          tmr_next = 32'h0000_0000;
        end else begin
          tmr_next = tmr_reg + 32'h0000_0001;
        end
      end
      default: phase_next = ISR_INIT;
    endcase
    if (tick && !filling_reg) begin
      filling_next = 1'b1;
      fill_next = 4'h0;
    end else if (filling_reg) begin
      fill_next = fill_reg + 4'h1;
      if (fill_reg == 4'(ISR_NREG - 1)) begin
        filling_next = 1'b0;
        done_next = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      phase_reg <= ISR_INIT;
      tmr_reg <= 32'h0000_0000;
      fill_reg <= 4'h0;
      filling_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      tmr_reg <= tmr_next;
      fill_reg <= fill_next;
      filling_reg <= filling_next;
      done_reg <= done_next;
    end
  end
  assign sample_done_pin = done_reg;

  // pin c: general output when not a sync input
  logic pin_c_out_reg, pin_c_oe_n_reg;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pin_c_out_reg <= 1'b0;
      pin_c_oe_n_reg <= 1'b1;
    end else begin
      pin_c_out_reg <= general_io_b_out;
      pin_c_oe_n_reg <= sync_mode_en | general_io_b_oe_n;
    end
  end
  assign sync_clock_input_pin_out = pin_c_out_reg;
  assign sync_clock_input_pin_oe_n = pin_c_oe_n_reg;

  // serial engine
  logic [15:0] rx_reg, rx_next, tx_reg, tx_next;
  logic [4:0] bit_reg, bit_next;
  logic [3:0] rd_idx_reg, rd_idx_next;
  logic burst_reg, burst_next;
  logic [3:0] bcnt_reg, bcnt_next;
  logic load_reg, load_next;
  logic miso_reg, miso_next;
  logic [15:0] rd_data;
  logic [15:0] full_word;

  // fresh flag set on refresh, cleared when the word is read
  always_comb begin
    fresh_next = fresh_reg;
    if (load_reg && rd_idx_reg != 4'hf) begin
      fresh_next[rd_idx_reg] = 1'b0;
    end
    if (filling_reg) begin
      fresh_next[fill_reg] = 1'b1; // refresh wins over the read clear
    end
  end

  isr_out_mem u_mem (
    .ref_clk(ref_clk),
    .wr_en(filling_reg),
    .wr_idx(fill_reg),
    .wr_data({2'b00, meas_data}),
    .rd_idx(rd_idx_next),
    .rd_data(rd_data)
  );
  always_comb begin
    full_word = rd_data;
    full_word[ISR_FRESH_BIT] = fresh_reg[rd_idx_reg];
    full_word[ISR_ALARM_BIT] = meas_alarm;
  end

  logic [15:0] req;
  always_comb begin
    req = {rx_reg[14:0], mosi_s};
    rx_next = rx_reg;
    tx_next = tx_reg;
    bit_next = bit_reg;
    rd_idx_next = rd_idx_reg;
    burst_next = burst_reg;
    bcnt_next = bcnt_reg;
    load_next = 1'b0;
    miso_next = miso_reg;
    if (cs_n_s) begin
      bit_next = 5'd0;
      miso_next = tx_reg[15];
      if (cs_rise) begin
        burst_next = 1'b0;
      end
    end else begin
      if (sclk_rise) begin
        rx_next = req;
        bit_next = bit_reg + 5'd1;
        if (bit_reg == 5'(ISR_WORD_BITS - 1)) begin
          bit_next = 5'd0;
          load_next = 1'b1;
          if (burst_reg) begin
            if (bcnt_reg == 4'(ISR_NREG - 1)) begin
              burst_next = 1'b0;
            end else begin
              bcnt_next = bcnt_reg + 4'h1;
              rd_idx_next = bcnt_reg + 4'h1;
            end
          end else if (req == ISR_BURST_CMD) begin
            burst_next = 1'b1;
            bcnt_next = 4'h0;
            rd_idx_next = 4'h0;
          end else if (!req[15] && !req[8] && req[14:8] >= ISR_FIRST_ADDR
                       && req[14:8] <= ISR_LAST_ADDR) begin
            rd_idx_next = 4'((req[14:8] - ISR_FIRST_ADDR) >> 1);
          end else begin
            rd_idx_next = 4'hf; // unmapped: reads zero
          end
        end
      end
      if (sclk_fall) begin
        miso_next = tx_reg[15];
        tx_next = {tx_reg[14:0], 1'b0};
      end
    end
    if (load_reg) begin
      // word for the request is shifted next frame
      tx_next = (rd_idx_reg == 4'hf) ? ISR_IDLE_WORD : full_word;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rx_reg <= 16'h0000;
      tx_reg <= 16'h0000;
      bit_reg <= 5'd0;
      rd_idx_reg <= 4'hf;
      burst_reg <= 1'b0;
      bcnt_reg <= 4'h0;
      load_reg <= 1'b0;
      miso_reg <= 1'b0;
      fresh_reg <= 14'h0000;
    end else begin
      rx_reg <= rx_next;
      tx_reg <= tx_next;
      bit_reg <= bit_next;
      rd_idx_reg <= rd_idx_next;
      burst_reg <= burst_next;
      bcnt_reg <= bcnt_next;
      load_reg <= load_next;
      miso_reg <= miso_next;
      fresh_reg <= fresh_next;
    end
  end
  assign spi_miso = miso_reg;

  a_done_after_fill: assert property (@(posedge ref_clk) disable iff (!rstn)
    (filling_reg && fill_reg == 4'(ISR_NREG - 1)) |=> sample_done_pin)
    else $error("done pulse missing");
  a_done_one_cycle: assert property (@(posedge ref_clk) disable iff (!rstn)
    sample_done_pin |=> !sample_done_pin)
    else $error("done pulse too long");
  a_miso_on_fall: assert property (@(posedge ref_clk) disable iff (!rstn)
    (!cs_n_s && !sclk_fall && !load_reg) |=> $stable(spi_miso))
    else $error("miso moved off falling edge");
  a_cs_abort: assert property (@(posedge ref_clk) disable iff (!rstn)
    cs_n_s |=> bit_reg == 5'd0)
    else $error("frame not aborted");
  a_burst_start: assert property (@(posedge ref_clk) disable iff (!rstn)
    (!cs_n_s && sclk_rise && bit_reg == 5'd15 && !burst_reg
     && req == ISR_BURST_CMD) |=> burst_reg && rd_idx_reg == 4'h0)
    else $error("burst not started");
  a_addr_decode: assert property (@(posedge ref_clk) disable iff (!rstn)
    (!cs_n_s && sclk_rise && bit_reg == 5'd15 && !burst_reg && req == 16'h0400)
    |=> rd_idx_reg == 4'h1)
    else $error("bad address decode");
  a_write_ignored: assert property (@(posedge ref_clk) disable iff (!rstn)
    (!cs_n_s && sclk_rise && bit_reg == 5'd15 && !burst_reg && req[15]
     && req != ISR_BURST_CMD) |=> rd_idx_reg == 4'hf)
    else $error("non-read decoded");
  // cycles since the last internal tick, kept apart from the sample timer
  logic [31:0] gap_reg, gap_next;
  always_comb begin
    gap_next = gap_reg + 32'h0000_0001;
    if (tick || sync_mode_en || phase_reg != ISR_RUN) begin
      gap_next = 32'h0000_0000;
    end
  end
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      gap_reg <= 32'h0000_0000;
    end else begin
      gap_reg <= gap_next;
    end
  end
  a_tick_rate: assert property (@(posedge ref_clk) disable iff (!rstn)
    gap_reg < ISR_SAMPLE_CYC)
    else $error("sample timer stuck");
  c_single: cover property (@(posedge ref_clk) disable iff (!rstn)
    load_reg && !burst_reg);
  c_burst_end: cover property (@(posedge ref_clk) disable iff (!rstn)
    burst_reg && bcnt_reg == 4'(ISR_NREG - 1));
  c_sync_tick: cover property (@(posedge ref_clk) disable iff (!rstn)
    sync_mode_en && tick);
endmodule : isr_spi_readout
`default_nettype wire

// >>> isr_spi_master_model.sv
`timescale 1ns/1ns
`default_nettype none
module isr_spi_master_model (
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_mosi,
  input wire logic spi_miso
);
  initial begin
    spi_sclk = 1'b1;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b1;
  end

  // clock idles high; keep_cs holds select low across burst words
  task automatic xfer(input logic [15:0] tx, input int nbits, input bit keep_cs,
                      output logic [15:0] rx);
    rx = 16'h0000;
    spi_cs_n = 1'b0;
    #50;
    for (int i = 0; i < nbits; i++) begin
      spi_sclk = 1'b0;
      spi_mosi = tx[15 - i];
      #40;
      spi_sclk = 1'b1;
      rx = {rx[14:0], spi_miso};
      #40;
    end
    if (!keep_cs) begin
      #10;
      spi_cs_n = 1'b1;
      // released line must not keep the last bit
      spi_mosi = ~spi_mosi;
    end
  endtask : xfer
endmodule : isr_spi_master_model
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import isr_pkg::*;
;
  logic ref_clk, rst_n, sclk, cs_n, mosi, miso, done, sy_out, sy_oe_n;
  logic [13:0] meas;
  logic alarm, sync_en, sync_in, gio_out, gio_oe_n;
  logic [15:0] rx, prev;
  logic [15:0] reqs[$];
  logic rd[14];
  int n_fail = 0, n_compared = 0, n_done = 0, cyc = 0, seed = 79;

  isr_spi_readout #(.INIT_CYC(100)) i_isr_spi_readout (.ref_clk(ref_clk), .rst_n(rst_n),
    .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso(miso), .meas_data(meas),
    .meas_alarm(alarm), .sync_mode_en(sync_en), .sample_done_pin(done),
    .sync_clock_input_pin_in(sync_in), .sync_clock_input_pin_out(sy_out),
    .sync_clock_input_pin_oe_n(sy_oe_n), .general_io_b_out(gio_out),
    .general_io_b_oe_n(gio_oe_n));
  isr_spi_master_model i_isr_spi_master_model (.spi_sclk(sclk), .spi_cs_n(cs_n),
    .spi_mosi(mosi), .spi_miso(miso));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic finish_test();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test

  always @(posedge ref_clk) begin
    cyc++;
    if (done === 1'b1) n_done++;
    if (cyc == 60000) begin
      n_fail++;
      finish_test();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // answer to a request, and the fresh flag it consumes
  task automatic expect_rd(input logic [15:0] req, input logic [15:0] got);
    logic [6:0] a;
    logic [3:0] k;
    a = req[14:8];
    k = 4'((a - ISR_FIRST_ADDR) >> 1);
    if (req[15] || req[8] || a < ISR_FIRST_ADDR || a > ISR_LAST_ADDR) begin
      chk(got, ISR_IDLE_WORD);
    end else begin
      chk(got, {~rd[k], alarm, meas});
      rd[k] = 1'b1;
    end
  endtask : expect_rd

  initial begin
    rst_n = 1'b0;
    meas = 14'($random(seed));
    alarm = 1'($random(seed));
    sync_en = 1'b0;
    sync_in = 1'b0;
    gio_out = 1'b1;
    gio_oe_n = 1'b0;
    foreach (rd[i]) rd[i] = 1'b0;
    repeat (12) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    for (int i = 0; i < 2000 && n_done == 0; i++) @(posedge ref_clk);
    chk(16'(n_done), 16'h0001);
    #1;
    chk({14'h0000, sy_out, sy_oe_n}, 16'h0002);
    gio_oe_n = 1'b1;
    sync_en = 1'b1;
    #20 chk({15'h0000, sy_oe_n}, 16'h0001);
    reqs = '{16'h0400, 16'h0600, 16'h0800, 16'h04A5, 16'h8400, 16'h0500, 16'h2000,
             16'h0000, 16'h1C00, 16'h0200};
    repeat (6) reqs.push_back({1'b0, 7'(2 + 2 * ($unsigned($random(seed)) % 14)),
                               8'($random(seed))});
    #7 i_isr_spi_master_model.xfer(16'h0A00, 5, 0, rx);
    #9000;
    foreach (reqs[i]) begin
      i_isr_spi_master_model.xfer(reqs[i], 16, 0, rx);
      if (i > 0) expect_rd(prev, rx);
      prev = reqs[i];
      #9000;
    end
    i_isr_spi_master_model.xfer(ISR_BURST_CMD, 16, 1, rx);
    expect_rd(prev, rx);
    for (int k = 0; k < 14; k++) begin
      i_isr_spi_master_model.xfer(16'h0000, 16, k < 13, rx);
      chk(rx, {~rd[k], alarm, meas});
      rd[k] = 1'b1;
    end
    #9000 i_isr_spi_master_model.xfer(16'h1C00, 16, 0, rx);
    #9000 i_isr_spi_master_model.xfer(16'h0000, 16, 0, rx);
    expect_rd(16'h1C00, rx);
    chk(16'(n_done), 16'h0001);
    // one external sync edge refreshes every word and sets its fresh flag
    @(posedge ref_clk);
    #1 sync_in = 1'b1;
    repeat (20) @(posedge ref_clk);
    #1 sync_in = 1'b0;
    repeat (20) @(posedge ref_clk);
    chk(16'(n_done), 16'h0002);
    foreach (rd[i]) rd[i] = 1'b0;
    #9000 i_isr_spi_master_model.xfer(16'h0400, 16, 0, rx);
    #9000 i_isr_spi_master_model.xfer(16'h0000, 16, 0, rx);
    expect_rd(16'h0400, rx);
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
